// ### sfoc_pkg.sv
// Constants shared by the flash operation control, and its page buffer.
// Assumes a single 50 MHz system clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

package sfoc_pkg;
    // ==========================================================
    // Instruction codes
    localparam logic [7:0] CMD_SET_LATCH = 8'h06;
    localparam logic [7:0] CMD_CLR_LATCH = 8'h04;
    localparam logic [7:0] CMD_STATUS_RD = 8'h05;
    localparam logic [7:0] CMD_STATUS_WR = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
    localparam logic [7:0] CMD_REGION_WIPE = 8'hD8;
    localparam logic [7:0] CMD_FULL_WIPE = 8'hC7;
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    // ==========================================================
    // Frame and array geometry
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [9:0] BYTES_ONE = 10'h001;
    localparam logic [9:0] BYTES_SR = 10'h002;
    localparam logic [9:0] BYTES_ADDR_END = 10'h004;
    localparam logic [9:0] BYTES_PP_MIN = 10'h005;
    localparam logic [9:0] BYTES_MAX = 10'h3FF;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ==========================================================
    // Status word bit positions
    localparam int SR_BUSY = 0;
    localparam int SR_LATCH = 1;
    localparam int SR_PROT_LO = 2;
    localparam int SR_PROT_HI = 4;
    localparam int SR_LOCK = 7;
    // ==========================================================
    // Pin vector positions after synchronisation
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_HOLD = 3;
    localparam int PIN_WP = 4;
    localparam int PIN_N = 5;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 50;
    localparam logic [31:0] CNT_DONE = 32'h0000_0001;
    localparam logic [31:0] CNT_ZERO = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_STATUS = 4'h2,
        ST_PROG = 4'h4,
        ST_ERASE = 4'h8
    } sfoc_state_t;

    // Read-only sectors selected by the protect level
    function automatic logic [15:0] sfoc_prot_map(input logic [2:0] lvl);
        unique case (lvl)
            3'h0: sfoc_prot_map = 16'h0000;
            3'h1: sfoc_prot_map = 16'h8000;
            3'h2: sfoc_prot_map = 16'hC000;
            3'h3: sfoc_prot_map = 16'hF000;
            3'h4: sfoc_prot_map = 16'hFF00;
            default: sfoc_prot_map = 16'hFFFF;
        endcase
    endfunction
endpackage

// ==========================================================
// Page buffer: one page of program data, registered read port
module sfoc_page_buf
    import sfoc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic set_write_latch_cmd, // write strobe
    input wire logic [7:0] wrAddr, // byte within page
    input wire logic [7:0] wrData, // byte to hold
    input wire logic rdEn, // read strobe
    input wire logic [7:0] rdAddr, // byte within page
    output logic [7:0] rdData_q // data one cycle after rdEn
);
    logic [7:0] mem [0:255];
    logic [7:0] rdData_d;

    always_comb
    begin
        rdData_d = rdEn ? mem[rdAddr] : rdData_q;
    end

    always_ff @(posedge clk)
    begin
        if (set_write_latch_cmd)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rdData_q <= ERASED_BYTE;
        end
        else
        begin
            rdData_q <= rdData_d;
        end
    end
endmodule
`default_nettype wire

// ### sfoc_main.sv
// Serial flash operation control: instruction framing, hold, write latch,
// protection, power modes and the busy cycle. The array itself is outside
// and is driven through byte-write and wipe strobes.
// Behaviour
// - Program: at most 256 bytes, one page
// - Wipe sector or whole array, timed
// - Status holds busy flag for polling
// - Active while selected or cycle running
// - Deep sleep until wake instruction
// - Deep sleep ignores all but wake
// - Modify instructions need whole-byte frames
// - Modify instructions need the write latch
// - Latch cleared at reset and on completion
// - Protect level selects read-only sectors
// - Protected sectors never wiped; program checks sector at start, writes follow addr_q as later frames shift it
// - Protect pin locks level and lock bits
// - Full wipe only with zero protect level
// - Power-up delay blocks modify instructions
// - Hold never stops an internal cycle
// - Hold starts only selected, clock low
// - Hold ends with pin high, clock low
// - Hold: output off, inputs ignored, state kept
// - Deselect in hold resets interface
`timescale 1ns/100ps
`default_nettype none

module sfoc_main
    import sfoc_pkg::*;
#(
    parameter int PROG_TIME_US = 5000,
    parameter int ERASE_TIME_US = 3000000,
    parameter int FULL_ERASE_TIME_US = 20000000,
    parameter int STATUS_TIME_US = 15000,
    parameter int PUW_TIME_US = 10000
)
(
    input wire logic clk, // system clock, 50 MHz
    input wire logic reset, // power-on reset, async, active high
    input wire logic sclkPin, // serial clock pin
    input wire logic csPinN, // chip select pin, active low
    input wire logic mosiPin, // serial data in pin
    input wire logic holdPinN, // pause pin, active low
    input wire logic wpPinN, // write protect pin, active low
    output logic misoOut, // serial data out level
    output logic misoOe, // serial data out enable
    output logic arrayWrEn, // program one byte (array ANDs it in)
    output logic [23:0] arrayWrAddr, // byte address to program
    output logic [7:0] arrayWrData, // byte to program
    output logic arraySectorWipe, // pulse: wipe sector to all ones
    output logic arrayFullWipe, // pulse: wipe whole array
    output logic [3:0] arrayWipeSector, // sector to wipe
    output logic busyFlag, // internal cycle running
    output logic writeLatch, // write latch bit
    output logic [2:0] protectLevel, // protect level bits
    output logic statusLock, // status lock bit
    output logic activeMode, // active power mode
    output logic deepSleep // deep power-down
);
    localparam logic [31:0] PROG_CYC = 32'(PROG_TIME_US * CLK_MHZ);
    localparam logic [31:0] ERASE_CYC = 32'(ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] FULL_CYC = 32'(FULL_ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] STATUS_CYC = 32'(STATUS_TIME_US * CLK_MHZ);
    localparam logic [31:0] PUW_CYC = 32'(PUW_TIME_US * CLK_MHZ);

    // ==========================================================
    // Pin synchronisers
    logic [PIN_N-1:0] sync1_q, sync2_q, sync3_q, filt_q, prev_q, filt_d;

    always_comb
    begin
        // Level moves only when stages two and three agree
        filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_q <= 5'h0A;
            sync2_q <= 5'h0A;
            sync3_q <= 5'h0A;
            filt_q <= 5'h0A;
            prev_q <= 5'h0A;
        end
        else
        begin
            sync1_q <= {wpPinN, holdPinN, mosiPin, csPinN, sclkPin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
        end
    end

    logic sclkLvl, csN, mosi, holdN, wpN, sclkRise, sclkFall, csRise;
    assign sclkLvl = filt_q[PIN_SCLK];
    assign csN = filt_q[PIN_CS];
    assign mosi = filt_q[PIN_MOSI];
    assign holdN = filt_q[PIN_HOLD];
    assign wpN = filt_q[PIN_WP];
    assign sclkRise = sclkLvl & ~prev_q[PIN_SCLK];
    assign sclkFall = ~sclkLvl & prev_q[PIN_SCLK];
    assign csRise = csN & ~prev_q[PIN_CS];

    // ==========================================================
    // Serial interface
    logic holdActive_q, holdActive_d, holdBlock_q, holdBlock_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [9:0] byteCnt_q, byteCnt_d;
    logic [7:0] shift_q, shift_d, opcode_q, opcode_d, srIn_q, srIn_d;
    logic [23:0] addr_q, addr_d;
    logic [8:0] dataCnt_q, dataCnt_d;
    logic misoOut_q, misoOut_d, misoOe_q, misoOe_d;
    logic selected, shiftEn, bufWrEn;
    logic [7:0] newByte, bufWrAddr;
    logic [7:0] statusWord;
    sfoc_state_t state_q, state_d;
    logic latch_q, latch_d, sleep_q, sleep_d, lock_q, lock_d;
    logic [2:0] prot_q, prot_d;

    assign selected = ~csN & ~holdBlock_q;
    assign shiftEn = selected & ~holdActive_q & sclkRise;
    assign newByte = {shift_q[6:0], mosi};
    assign bufWrAddr = 8'(addr_q[7:0] + dataCnt_q[7:0]);
    assign statusWord = {lock_q, 2'h0, prot_q, latch_q, state_q != ST_IDLE};
    assign bufWrEn = shiftEn && bitCnt_q == BIT_LAST && opcode_q == CMD_PAGE_PROG
                     && byteCnt_q >= BYTES_ADDR_END && state_q == ST_IDLE && !sleep_q;

    always_comb
    begin
        holdActive_d = holdActive_q;
        holdBlock_d = holdBlock_q;
        bitCnt_d = bitCnt_q;
        byteCnt_d = byteCnt_q;
        shift_d = shift_q;
        opcode_d = opcode_q;
        srIn_d = srIn_q;
        addr_d = addr_q;
        dataCnt_d = dataCnt_q;
        misoOut_d = misoOut_q;
        if (csN)
        begin
            if (csRise && holdActive_q)
            begin
                holdBlock_d = 1'b1;
            end
            else if (holdN)
            begin
                holdBlock_d = 1'b0;
            end
            holdActive_d = 1'b0;
            bitCnt_d = 3'h0;
            byteCnt_d = 10'h000;
            dataCnt_d = 9'h000;
        end
        else if (selected && !sclkLvl)
        begin
            holdActive_d = ~holdN;
        end
        if (shiftEn)
        begin
            shift_d = newByte;
            bitCnt_d = 3'(bitCnt_q + 3'h1);
            if (bitCnt_q == BIT_LAST)
            begin
                if (byteCnt_q != BYTES_MAX)
                begin
                    byteCnt_d = 10'(byteCnt_q + BYTES_ONE);
                end
                if (byteCnt_q == 10'h000)
                begin
                    opcode_d = newByte;
                end
                else if (byteCnt_q < BYTES_ADDR_END)
                begin
                    addr_d = {addr_q[15:0], newByte};
                end
                if (byteCnt_q == BYTES_ONE)
                begin
                    srIn_d = newByte;
                end
                if (bufWrEn && dataCnt_q != PAGE_BYTES)
                begin
                    dataCnt_d = 9'(dataCnt_q + 9'h001);
                end
            end
        end
        if (selected && !holdActive_q && sclkFall)
        begin
            misoOut_d = statusWord[BIT_LAST - bitCnt_q];
        end
    end

    always_comb
    begin
        misoOe_d = selected && !holdActive_q && !sleep_q
                   && opcode_q == CMD_STATUS_RD && byteCnt_q != 10'h000;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            holdActive_q <= 1'b0;
            holdBlock_q <= 1'b0;
            bitCnt_q <= 3'h0;
            byteCnt_q <= 10'h000;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            srIn_q <= 8'h00;
            addr_q <= 24'h000000;
            dataCnt_q <= 9'h000;
            misoOut_q <= 1'b0;
            misoOe_q <= 1'b0;
        end
        else
        begin
            holdActive_q <= holdActive_d;
            holdBlock_q <= holdBlock_d;
            bitCnt_q <= bitCnt_d;
            byteCnt_q <= byteCnt_d;
            shift_q <= shift_d;
            opcode_q <= opcode_d;
            srIn_q <= srIn_d;
            addr_q <= addr_d;
            dataCnt_q <= dataCnt_d;
            misoOut_q <= misoOut_d;
            misoOe_q <= misoOe_d;
        end
    end

    // ==========================================================
    // Page buffer
    logic rdEn;
    logic [7:0] rdPtr_q, rdPtr_d;

    sfoc_page_buf u_buf (
        .clk(clk),
        .reset(reset),
        .set_write_latch_cmd(bufWrEn),
        .wrAddr(bufWrAddr),
        .wrData(newByte),
        .rdEn(rdEn),
        .rdAddr(rdPtr_q),
        .rdData_q(arrayWrData)
    );

    // ==========================================================
    // Dispatch and internal cycle
    logic [31:0] timer_q, timer_d, puw_q, puw_d;
    logic [8:0] walk_q, walk_d;
    logic set_write_latch_cmd_q, set_write_latch_cmd_d, secWipe_q, secWipe_d, fullWipe_q, fullWipe_d;
    logic srApply_q, srApply_d, canMod, frameOk;
    logic [15:0] protMap;

    assign protMap = sfoc_prot_map(prot_q);
    assign canMod = latch_q && puw_q == CNT_ZERO;
    assign frameOk = csRise && !holdActive_q && !holdBlock_q
                     && bitCnt_q == 3'h0 && byteCnt_q != 10'h000;
    assign rdEn = state_q == ST_PROG && walk_q != 9'h000;

    always_comb
    begin
        state_d = state_q;
        timer_d = timer_q;
        puw_d = (puw_q == CNT_ZERO) ? puw_q : 32'(puw_q - CNT_DONE);
        walk_d = walk_q;
        rdPtr_d = rdPtr_q;
        set_write_latch_cmd_d = rdEn;
        secWipe_d = 1'b0;
        fullWipe_d = 1'b0;
        srApply_d = srApply_q;
        latch_d = latch_q;
        sleep_d = sleep_q;
        lock_d = lock_q;
        prot_d = prot_q;
        if (rdEn)
        begin
            rdPtr_d = 8'(rdPtr_q + 8'h01);
            walk_d = 9'(walk_q - 9'h001);
        end
        unique case (state_q)
            ST_IDLE:
            begin
                if (frameOk && sleep_q)
                begin
                    sleep_d = opcode_q != CMD_WAKE;
                end
                else if (frameOk)
                begin
                    unique case (opcode_q)
                        CMD_SET_LATCH: latch_d = 1'b1;
                        CMD_CLR_LATCH: latch_d = 1'b0;
                        CMD_DEEP_SLEEP: sleep_d = 1'b1;
                        CMD_STATUS_WR:
                        begin
                            if (canMod && byteCnt_q >= BYTES_SR)
                            begin
                                state_d = ST_STATUS;
                                timer_d = STATUS_CYC;
                                srApply_d = !(lock_q && !wpN);
                            end
                        end
                        CMD_PAGE_PROG:
                        begin
                            if (canMod && byteCnt_q >= BYTES_PP_MIN && !protMap[addr_q[23:20]])
                            begin
                                state_d = ST_PROG;
                                timer_d = PROG_CYC;
                                walk_d = dataCnt_q;
                                rdPtr_d = (dataCnt_q == PAGE_BYTES) ? 8'h00 : addr_q[7:0];
                            end
                        end
                        CMD_REGION_WIPE:
                        begin
                            if (canMod && byteCnt_q >= BYTES_ADDR_END && !protMap[addr_q[23:20]])
                            begin
                                state_d = ST_ERASE;
                                timer_d = ERASE_CYC;
                                secWipe_d = 1'b1;
                            end
                        end
                        CMD_FULL_WIPE:
                        begin
                            if (canMod && prot_q == 3'h0)
                            begin
                                state_d = ST_ERASE;
                                timer_d = FULL_CYC;
                                fullWipe_d = 1'b1;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            ST_STATUS, ST_PROG, ST_ERASE:
            begin
                // Runs on regardless of hold or select, busy till done
                timer_d = 32'(timer_q - CNT_DONE);
                if (timer_q == CNT_DONE)
                begin
                    state_d = ST_IDLE;
                    latch_d = 1'b0;
                    if (state_q == ST_STATUS && srApply_q)
                    begin
                        lock_d = srIn_q[SR_LOCK];
                        prot_d = srIn_q[SR_PROT_HI:SR_PROT_LO];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            timer_q <= CNT_ZERO;
            puw_q <= PUW_CYC;
            walk_q <= 9'h000;
            rdPtr_q <= 8'h00;
            set_write_latch_cmd_q <= 1'b0;
            secWipe_q <= 1'b0;
            fullWipe_q <= 1'b0;
            srApply_q <= 1'b0;
            latch_q <= 1'b0;
            sleep_q <= 1'b0;
            lock_q <= 1'b0;
            prot_q <= 3'h0;
            arrayWrAddr <= 24'h000000;
        end
        else
        begin
            state_q <= state_d;
            timer_q <= timer_d;
            puw_q <= puw_d;
            walk_q <= walk_d;
            rdPtr_q <= rdPtr_d;
            set_write_latch_cmd_q <= set_write_latch_cmd_d;
            secWipe_q <= secWipe_d;
            fullWipe_q <= fullWipe_d;
            srApply_q <= srApply_d;
            latch_q <= latch_d;
            sleep_q <= sleep_d;
            lock_q <= lock_d;
            prot_q <= prot_d;
            arrayWrAddr <= {addr_q[23:8], rdPtr_q};
        end
    end

    assign misoOut = misoOut_q;
    assign misoOe = misoOe_q;
    assign arrayWrEn = set_write_latch_cmd_q;
    assign arraySectorWipe = secWipe_q;
    assign arrayFullWipe = fullWipe_q;
    assign arrayWipeSector = addr_q[23:20];
    assign busyFlag = ~state_q[0];
    assign writeLatch = latch_q;
    assign protectLevel = prot_q;
    assign statusLock = lock_q;
    assign deepSleep = sleep_q;
    assign activeMode = ~csN | busyFlag;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_busy_start; $rose(busyFlag) |-> $past(frameOk) && $past(latch_q); endproperty
    a_busy_start: assert property (p_busy_start) else $error("cycle began without latch");
    property p_frame; $rose(busyFlag) |-> $past(bitCnt_q) == 3'h0; endproperty
    a_frame: assert property (p_frame) else $error("cycle began on partial byte");
    property p_latch_clr; $fell(busyFlag) |-> !writeLatch; endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept after cycle");
    property p_sleep; deepSleep |=> !$rose(busyFlag); endproperty
    a_sleep: assert property (p_sleep) else $error("cycle began in deep sleep");
    property p_full; arrayFullWipe |-> protectLevel == 3'h0; endproperty
    a_full: assert property (p_full) else $error("full wipe while protected");
    property p_sector; arraySectorWipe |-> !protMap[arrayWipeSector]; endproperty
    a_sector: assert property (p_sector) else $error("protected sector wiped");
    property p_puw; puw_q != CNT_ZERO |=> !$rose(busyFlag); endproperty
    a_puw: assert property (p_puw) else $error("modify during power-up delay");
    property p_hold_q; holdActive_q |=> !misoOe; endproperty
    a_hold_q: assert property (p_hold_q) else $error("output driven in hold");
    property p_hold_cyc; busyFlag && timer_q > CNT_DONE |=> busyFlag; endproperty
    a_hold_cyc: assert property (p_hold_cyc) else $error("cycle stopped early");
    property p_active; !csN |-> activeMode; endproperty
    a_active: assert property (p_active) else $error("selected but not active");
    property p_wr_page; arrayWrEn |-> arrayWrAddr[23:8] == addr_q[23:8]; endproperty
    a_wr_page: assert property (p_wr_page) else $error("program left the page");

    c_prog: cover property (state_q == ST_PROG ##1 arrayWrEn);
    c_erase: cover property (arraySectorWipe);
    c_hold: cover property ($rose(holdActive_q));
    c_sleep: cover property ($fell(deepSleep));
endmodule
`default_nettype wire

// ### sfoc_spi_master.sv
// Bus master model driving the serial pins.
// Assumes the bench clock paces it; sclk idles low.
`timescale 1ns/100ps
`default_nettype none
module sfoc_spi_master
(
    input wire logic clk, // bench clock
    input wire logic miso, // serial data out, pulled high when released
    output logic sclk, // serial clock
    output logic csN, // chip select
    output logic mosi, // serial data
    output logic holdN, // pause pin
    output logic [7:0] rx // last eight bits seen on serial data out
);
    // ==========================================================
    // Frames of n bits, MSB first; optional pause before bit holdAt
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
        holdN = 1'b1;
        rx = 8'h00;
    end
    task automatic frame(input logic [63:0] v, input int n, input int holdAt, input bit cut);
        @(negedge clk);
        csN = 1'b0;
        for (int i = n - 1; i >= 0 && !csN; i--)
        begin
            if (i == holdAt)
            begin
                holdN = 1'b0;
                repeat (2)
                begin
                    repeat (4) @(negedge clk);
                    sclk = 1'b1;
                    mosi = ~mosi; // Paused: clock and data must be ignored
                    repeat (4) @(negedge clk);
                    sclk = 1'b0;
                end
                repeat (4) @(negedge clk);
                csN = cut;
                repeat (8) @(negedge clk);
                holdN = 1'b1;
                repeat (4) @(negedge clk);
            end
            if (!csN)
            begin
                mosi = v[i];
                repeat (4) @(negedge clk);
                sclk = 1'b1;
                repeat (4) @(negedge clk);
                rx = {rx[6:0], miso}; // Late sample: the block answers some clocks after a fall
                sclk = 1'b0;
            end
        end
        repeat (4) @(negedge clk);
        csN = 1'b1;
        mosi = ~mosi; // Released line must not look valid
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ### tb_serial_flash_operation_control.sv
// Self-checking bench for sfoc_main.
// Assumes short cycle times set by parameters below.
`timescale 1ns/100ps
`default_nettype none
module tb_serial_flash_operation_control;
    import sfoc_pkg::*;
    logic clk, reset, wpN, sclk, csN, mosi, holdN, mOut, mOe, set_write_latch_cmd, sWipe, fWipe;
    logic busy, latch, lock, act, sleep;
    logic [23:0] wrAddr;
    logic [7:0] wrData, d0, d1, off, rx;
    logic [3:0] sec;
    logic [2:0] lvl;
    logic [11:0] pg;
    logic [33:0] got;
    logic [33:0] expQ[$];
    int err_total, num_checks, cycles;
    sfoc_main #(.PROG_TIME_US(10), .ERASE_TIME_US(2), .FULL_ERASE_TIME_US(3),
        .STATUS_TIME_US(2), .PUW_TIME_US(10)) i_sfoc_main (.clk(clk), .reset(reset),
        .sclkPin(sclk), .csPinN(csN), .mosiPin(mosi), .holdPinN(holdN), .wpPinN(wpN),
        .misoOut(mOut), .misoOe(mOe), .arrayWrEn(set_write_latch_cmd), .arrayWrAddr(wrAddr),
        .arrayWrData(wrData), .arraySectorWipe(sWipe), .arrayFullWipe(fWipe),
        .arrayWipeSector(sec), .busyFlag(busy), .writeLatch(latch), .protectLevel(lvl),
        .statusLock(lock), .activeMode(act), .deepSleep(sleep));
    sfoc_spi_master i_sfoc_spi_master (.clk(clk), .miso(mOe ? mOut : 1'b1), .sclk(sclk), .csN(csN),
        .mosi(mosi), .holdN(holdN), .rx(rx));
    // ==========================================================
    // Clock, timeout, checking
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_total++;
            conclude();
        end
    end
    // Monitor: each array strobe takes the oldest note
    always @(posedge clk)
    begin
        if (set_write_latch_cmd === 1'b1 || sWipe === 1'b1 || fWipe === 1'b1)
        begin
            got = {sWipe, fWipe, set_write_latch_cmd ? {wrAddr, wrData} : (sWipe ? {20'h0, sec, 8'h0} : 32'h0)};
            if (expQ.size() == 0)
                check(got, ~got);
            else
                check(got, expQ.pop_front());
        end
    end
    // ==========================================================
    // Helpers
    task automatic fr(input logic [63:0] v, input int n, input int holdAt = -1, input bit cut = 1'b0);
        i_sfoc_spi_master.frame(v, n, holdAt, cut);
        repeat (12) @(negedge clk);
    endtask
    task automatic waitIdle(input string name);
        for (int i = 0; i < 2000 && busy !== 1'b0; i++)
            @(negedge clk);
        check({33'h0, busy}, 34'h0);
        check(34'(expQ.size()), 34'h0);
        $display("test %s done", name);
    endtask
    // ==========================================================
    // Tests
    initial
    begin
        reset = 1'b1;
        wpN = 1'b1;
        err_total = 0;
        num_checks = 0;
        cycles = 0;
        void'($urandom(81));
        repeat (3) @(negedge clk);
        reset = 1'b0;
        fr(64'h06, 8);
        fr({32'h0, 8'hD8, 24'h000000}, 32);
        check({32'h0, busy, latch}, 34'h1);
        repeat (300) @(negedge clk);
        fr(64'h06, 8);
        check({33'h0, latch}, 34'h1);
        fr(64'h04, 8);
        check({33'h0, latch}, 34'h0);
        fr({16'h0, 8'h02, 24'h100000, 16'hA55A}, 48);
        check({33'h0, busy}, 34'h0);
        waitIdle("latch");
        fr(64'h06, 8, 4);
        check({33'h0, latch}, 34'h1);
        fr(64'h0400, 16, 7, 1'b1);
        check({33'h0, latch}, 34'h1);
        $display("test hold done");
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        pg = 12'($urandom);
        off = 8'hFF;
        fr(64'h06, 8);
        expQ.push_back({2'b00, 4'h1, pg, off, d0});
        expQ.push_back({2'b00, 4'h1, pg, 8'h00, d1}); // Page wrap
        i_sfoc_spi_master.frame({16'h0, 8'h02, 4'h1, pg, off, d0, d1}, 48, -1, 1'b0);
        check({33'h0, busy}, 34'h1);
        check({33'h0, act}, 34'h1);
        fr(64'h0500, 16);
        check({26'h0, rx}, 34'h03);
        waitIdle("program");
        check({32'h0, latch, act}, 34'h0);
        fr(64'h06, 8);
        fr({32'h0, 8'hD8, 24'h200000} >> 1, 31);
        check({32'h0, busy, latch}, 34'h1);
        expQ.push_back({2'b10, 20'h0, 4'h2, 8'h0});
        fr({32'h0, 8'hD8, 24'h200000}, 32);
        waitIdle("wipe");
        fr(64'h06, 8);
        fr(64'h0184, 16);
        waitIdle("level");
        check({30'h0, lock, lvl}, 34'h9);
        fr(64'h0500, 16);
        check({26'h0, rx}, 34'h84);
        fr(64'h06, 8);
        fr({32'h0, 8'hD8, 24'hF00000}, 32);
        check({33'h0, busy}, 34'h0);
        fr(64'hC7, 8);
        check({33'h0, busy}, 34'h0);
        wpN = 1'b0;
        fr(64'h0100, 16);
        waitIdle("protect");
        check({30'h0, lock, lvl}, 34'h9);
        wpN = 1'b1;
        fr(64'h06, 8);
        fr(64'h0100, 16);
        waitIdle("unlock");
        check({30'h0, lock, lvl}, 34'h0);
        fr(64'h06, 8);
        expQ.push_back({2'b01, 32'h0});
        fr(64'hC7, 8);
        waitIdle("full");
        fr(64'hB9, 8);
        check({33'h0, sleep}, 34'h1);
        fr(64'h06, 8);
        check({33'h0, latch}, 34'h0);
        fr(64'hAB, 8);
        check({33'h0, sleep}, 34'h0);
        $display("test sleep done");
        conclude();
    end
endmodule
`default_nettype wire
